// ### common/csq_pkg.sv
`default_nettype none
package csq_pkg;
  // ----------------------------------------
  // phase select codes
  // ----------------------------------------
  typedef logic [3:0] csq_sel_t;
  typedef logic [2:0] csq_ph_t;
  localparam csq_sel_t SEL_KEEP   = 4'h8; // hold current state
  localparam csq_sel_t SEL_DONE   = 4'h9; // follow the done output
  localparam csq_sel_t SEL_SKIP_WAIT_SETTING = 4'hA; // skip a wait phase
  localparam csq_sel_t SEL_AUTO   = 4'hB; // match phase chosen by design
  localparam csq_sel_t SEL_MAXPH  = 4'h6; // last selectable phase
  localparam csq_sel_t DEF_DONE   = 4'h4;
  localparam csq_sel_t DEF_GTS    = 4'h5;
  localparam csq_sel_t DEF_GWE    = 4'h6;
  localparam csq_sel_t AUTO_MATCH = 4'h2; // match phase for calibrated io
  localparam csq_ph_t  PH_FIRST   = 3'h0;
  localparam csq_ph_t  PH_LAST    = 3'h7;
  localparam csq_ph_t  PH_STEP    = 3'h1;
  // ----------------------------------------
  // option enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {SEC_NONE, SEC_L1, SEC_L2} csq_sec_t;
  typedef enum logic [1:0] {MON_EN, MON_DIS, MON_STAT} csq_mon_t;
  typedef enum logic [1:0] {PORT_AUTO, PORT_TOP, PORT_BOT} csq_port_t;
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_END} csq_st_t;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    csq_sel_t  doneSel;
    csq_sel_t  gtsSel;
    csq_sel_t  gweSel;
    csq_sel_t  lockSel;
    csq_sel_t  matchSel;
    logic      done_pipeline_option;
    logic      frameCrcEn;
    logic      active_reconfig_option;
    logic      jtagDisable;
    logic      monPowerDown;
    logic      usesImpIo;
    csq_sec_t  security;
    csq_mon_t  jtagMon;
    csq_port_t portSel;
  } csq_opt_t;
  typedef struct packed {
    logic doneOut;
    logic ioTristate;
    logic writeEnable;
    logic memEnable;
    logic hold;
    logic setReset;
  } csq_glob_t;
  typedef struct packed {
    logic readbackOk;
    logic reconfigOk;
    logic bscanOk;
    logic monJtagEn;
    logic monStatusOnly;
    logic portTop;
    logic portBottom;
    logic monPowerDown;
  } csq_acc_t;
endpackage
`default_nettype wire

// ### rtl/csq_startup_seq.sv
// Behaviour
// (RL1) done rises in chosen phase, default 4
// (RL2) pipelined done comes one edge later
// (RL3) io tristate released in chosen phase
// (RL4) write enable rises in chosen phase
// (RL5) block memories off before write enable
// (RL6) hold in lock phase until clocks lock
// (RL7) stall in match phase until matched
// (RL8) match phase only waits, starts nothing
// (RL9) source keeps clock running until done
// (RL10) auto match uses phase 2 or none
// (RL11) frame crc mismatch flags both error outputs
// (RL12) active reconfig suppresses hold and reset
// (RL13) level 1 refuses readback
// (RL14) jtag disable blocks scan after config
// (RL15) monitor jtag path enabled, off, status
// (RL16) access port top, bottom or auto
// (RL17) monitor powered down when selected
// (RL18) phase steps once per clock edge
// (RL19) level 2 refuses readback and reconfig
`timescale 1ns/1ps
`default_nettype none
module csq_startup_seq
  import csq_pkg::*;
(
  // system
  input  wire logic mclk,
  input  wire logic rst_n,
  // link from the configuration source
  input  wire logic configurationClock,
  // loader events, same clock
  input  wire logic cfgLoaded,
  input  wire logic reconfigReq,
  input  wire logic crcCheck,
  input  wire logic crcMismatch,
  // fabric status pins
  input  wire logic clockLock,
  input  wire logic impMatch,
  // options
  input  wire csq_opt_t opt,
  // global controls
  output csq_glob_t glob,
  // access controls
  output csq_acc_t  acc,
  // error reporting
  output logic      initErrN,
  output logic      partialReconfigErrorOut,
  output logic      loadBlock
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic    clkS1;   // synchroniser first stage
    logic    clkS2;   // synchronised link clock
    logic    clkS3;   // previous sample, edge find
    logic    lockS1;
    logic    lockS2;
    logic    matchS1;
    logic    matchS2;
    csq_st_t st;      // sequencer state
    csq_ph_t phase;   // startup phase counter
    logic    doneHit; // done phase reached
    logic    doneOut; // done output flop
    logic    ioRel;   // io released
    logic    weOn;    // write enable on
    logic    crcErr;  // sticky crc error
  } csq_state_t;

  csq_state_t s_r;   // registered state
  csq_state_t s_nxt; // next state
  logic       clkRise;
  logic       stall;
  logic       hitDone;
  csq_sel_t   matchEff;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // true when a numeric select names this phase
  function automatic logic selHit(csq_sel_t sel, csq_ph_t ph);
    selHit = (sel <= SEL_MAXPH) && (sel[2:0] == ph);
  endfunction

  // auto resolves from the design's io use
  function automatic csq_sel_t effMatch(csq_sel_t sel, logic imp);
    if (sel == SEL_AUTO) begin
      effMatch = imp ? AUTO_MATCH : SEL_SKIP_WAIT_SETTING; // RL10
    end else begin
      effMatch = sel;
    end
  endfunction

  // ----------------------------------------
  // edge and stall decode
  // ----------------------------------------
  always_comb begin
    clkRise  = s_r.clkS2 & ~s_r.clkS3;
    matchEff = effMatch(opt.matchSel, opt.usesImpIo);
    // the match wait only samples a match already
    // running; nothing here kicks calibration off
    stall = (selHit(opt.lockSel, s_r.phase) & ~s_r.lockS2) // RL6
          | (selHit(matchEff, s_r.phase) & ~s_r.matchS2); // RL7 RL8
    hitDone = s_r.doneHit | selHit(opt.doneSel, s_r.phase);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    // link clock, lock and match pins pass two flops before use
    s_nxt.clkS1   = configurationClock;
    s_nxt.clkS2   = s_r.clkS1;
    s_nxt.clkS3   = s_r.clkS2;
    s_nxt.lockS1  = clockLock;
    s_nxt.lockS2  = s_r.lockS1;
    s_nxt.matchS1 = impMatch;
    s_nxt.matchS2 = s_r.matchS1;
    // frame crc error is sticky; set wins over clear
    if (s_r.st == ST_END && reconfigReq && acc.reconfigOk) begin
      s_nxt.crcErr = 1'b0;
    end
    if (opt.frameCrcEn && crcCheck && crcMismatch) begin
      s_nxt.crcErr = 1'b1; // RL11
    end
    // controlled outputs rise on link edges only
    if (s_r.st != ST_LOAD && clkRise) begin
      s_nxt.doneHit = hitDone; // RL1
      if (opt.done_pipeline_option) begin
        // one extra edge of delay
        s_nxt.doneOut = s_r.doneOut | s_r.doneHit; // RL2
      end else begin
        s_nxt.doneOut = s_r.doneOut | hitDone; // RL1
      end
      // release of io tristate
      if (opt.gtsSel == SEL_DONE) begin
        s_nxt.ioRel = s_r.ioRel | s_nxt.doneOut; // RL3
      end else begin
        s_nxt.ioRel = s_r.ioRel | selHit(opt.gtsSel, s_r.phase); // RL3
      end
      // write enable
      if (opt.gweSel == SEL_DONE) begin
        s_nxt.weOn = s_r.weOn | s_nxt.doneOut; // RL4
      end else begin
        s_nxt.weOn = s_r.weOn | selHit(opt.gweSel, s_r.phase); // RL4
      end
    end
    unique case (s_r.st)
      // waiting for the loader to finish
      ST_LOAD: begin
        if (cfgLoaded) begin
          s_nxt.st    = ST_RUN;
          s_nxt.phase = PH_FIRST;
        end
      end
      // stepping through phases
      ST_RUN: begin
        if (clkRise && !stall) begin
          if (s_r.phase == PH_LAST) begin
            s_nxt.st = ST_END;
          end else begin
            s_nxt.phase = s_r.phase + PH_STEP; // RL18
          end
        end
      end
      // finished; reconfig only where allowed
      ST_END: begin
        if (reconfigReq && acc.reconfigOk) begin // RL19
          s_nxt.st      = ST_LOAD;
          s_nxt.phase   = PH_FIRST;
          s_nxt.doneHit = 1'b0;
          s_nxt.doneOut = 1'b0;
          s_nxt.ioRel   = 1'b0;
          s_nxt.weOn    = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    glob.doneOut     = s_r.doneOut;
    glob.ioTristate  = ~s_r.ioRel;
    glob.writeEnable = s_r.weOn;
    // memories follow write enable so no read or
    // write can hit half-loaded contents
    glob.memEnable   = s_r.weOn; // RL5
    // partial designs keep running, so no hold
    glob.hold     = ~opt.active_reconfig_option
                  & (s_r.st == ST_LOAD); // RL12
    glob.setReset = ~opt.active_reconfig_option & ~s_r.weOn; // RL12
    acc.readbackOk    = (opt.security == SEC_NONE); // RL13 RL19
    acc.reconfigOk    = (opt.security != SEC_L2); // RL19
    // scan blocked only after config completes
    acc.bscanOk       = ~(opt.jtagDisable
                        & (s_r.st == ST_END)); // RL14
    acc.monJtagEn     = (opt.jtagMon != MON_DIS); // RL15
    acc.monStatusOnly = (opt.jtagMon == MON_STAT); // RL15
    // auto picks the top port
    acc.portTop       = (opt.portSel != PORT_BOT); // RL16
    acc.portBottom    = (opt.portSel == PORT_BOT); // RL16
    acc.monPowerDown  = opt.monPowerDown; // RL17
    initErrN                = ~s_r.crcErr; // RL11
    partialReconfigErrorOut = s_r.crcErr; // RL11
    // with frame crc enabled, loading stops once a bad frame is seen
    loadBlock               = s_r.crcErr; // RL11
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_phase_step: assert property ( // RL18
    s_r.st == ST_RUN && clkRise && !stall
    && s_r.phase != PH_LAST
    |=> s_r.phase == csq_ph_t'($past(s_r.phase) + PH_STEP))
    else $error("phase did not step");

  a_lock_hold: assert property ( // RL6
    s_r.st == ST_RUN && selHit(opt.lockSel, s_r.phase)
    && !s_r.lockS2 |=> $stable(s_r.phase) && s_r.st == ST_RUN)
    else $error("left lock phase without lock");

  a_match_hold: assert property ( // RL7
    s_r.st == ST_RUN && selHit(matchEff, s_r.phase)
    && !s_r.matchS2 |=> $stable(s_r.phase))
    else $error("left match phase without match");

  // auto with calibrated io must really hold phase 2
  a_auto_match: assert property ( // RL10
    s_r.st == ST_RUN && opt.matchSel == SEL_AUTO && opt.usesImpIo
    && s_r.phase == csq_ph_t'(AUTO_MATCH) && !s_r.matchS2
    |=> $stable(s_r.phase))
    else $error("auto match phase did not wait");

  // auto without calibrated io must never stall on match
  a_auto_none: assert property ( // RL10
    s_r.st == ST_RUN && clkRise && opt.matchSel == SEL_AUTO
    && !opt.usesImpIo && !selHit(opt.lockSel, s_r.phase)
    && s_r.phase != PH_LAST |=> s_r.phase != $past(s_r.phase))
    else $error("auto match stalled without calibrated io");

  a_done_now: assert property ( // RL1
    s_r.st == ST_RUN && clkRise && !opt.done_pipeline_option
    && selHit(opt.doneSel, s_r.phase) |=> glob.doneOut)
    else $error("done missed its phase");

  a_done_pipe: assert property ( // RL2
    opt.done_pipeline_option && $rose(glob.doneOut)
    |-> $past(s_r.doneHit))
    else $error("pipelined done too early");

  // a reload has to shut the memories again, not only reset
  a_mem_block: assert property ( // RL5
    (!glob.writeEnable || s_r.st == ST_LOAD) |-> !glob.memEnable)
    else $error("memory enabled before write enable");

  a_no_hold: assert property ( // RL12
    opt.active_reconfig_option |-> !glob.hold && !glob.setReset)
    else $error("hold asserted under active reconfig");

  a_sec_levels: assert property ( // RL13
    opt.security == SEC_L1 |-> !acc.readbackOk && acc.reconfigOk)
    else $error("level 1 access wrong");

  a_sec_two: assert property ( // RL19
    opt.security == SEC_L2 && s_r.st == ST_END && reconfigReq
    |=> s_r.st == ST_END && !acc.readbackOk)
    else $error("level 2 allowed reconfig");

  a_crc_flag: assert property ( // RL11
    opt.frameCrcEn && crcCheck && crcMismatch
    |=> !initErrN && partialReconfigErrorOut && loadBlock)
    else $error("crc error not flagged");

  a_jtag_off: assert property ( // RL14
    opt.jtagDisable && s_r.st == ST_END |-> !acc.bscanOk)
    else $error("scan open after config");

  c_done_seen: cover property ($rose(glob.doneOut));
  c_lock_stall: cover property (
    stall && selHit(opt.lockSel, s_r.phase) [*3]);
  c_crc_err: cover property ($rose(s_r.crcErr));
  c_reconfig: cover property (
    s_r.st == ST_END ##1 s_r.st == ST_LOAD);

endmodule
`default_nettype wire

// ### sim/csq_cfg_source.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// configuration source: drives the link clock
// ----------------------------------------
module csq_cfg_source #(
  parameter int TAIL_EDGES = 8 // extra edges sent after done is seen
) (
  // control from the bench
  input  wire logic run,
  input  wire logic slow,
  // status from the device
  input  wire logic doneIn,
  // link clock
  output logic      linkClk
);
  int tail; // edges sent since done was seen high
  // clock stands low between frames; period stays 400 ns,
  // slow only stretches the high time
  initial begin
    linkClk = 1'h0;
    tail    = 0;
    forever begin
      // a new frame restarts the tail count
      wait (run);
      tail = 0;
      while (run && tail < TAIL_EDGES) begin
        #(slow ? 137 : 187);
        // no edge once the bench has closed the frame
        if (run) begin
          linkClk = 1'h1;
          #(slow ? 263 : 213) linkClk = 1'h0;
          // startup length varies, so only stop once done shows
          if (doneIn) tail = tail + 1;
        end
      end
      wait (!run);
    end
  end
endmodule
`default_nettype wire

// ### sim/csq_startup_seq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module csq_startup_seq_tb_top import csq_pkg::*;;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic      mclk, rst_n, linkClk, cfgLoaded, reconfigReq;
  logic      crcCheck, crcMismatch, clockLock, impMatch, run, slow;
  logic      initErrN, prErr, loadBlock;
  csq_opt_t  opt;
  csq_glob_t glob;
  csq_acc_t  acc;
  int        errTotal = 0; // mismatches seen
  int        cmpCount = 0; // comparisons made
  int        cycles   = 0; // watchdog count
  csq_startup_seq DUT (.mclk(mclk), .rst_n(rst_n),
    .configurationClock(linkClk), .cfgLoaded(cfgLoaded),
    .reconfigReq(reconfigReq), .crcCheck(crcCheck),
    .crcMismatch(crcMismatch), .clockLock(clockLock),
    .impMatch(impMatch), .opt(opt), .glob(glob), .acc(acc),
    .initErrN(initErrN), .partialReconfigErrorOut(prErr),
    .loadBlock(loadBlock));
  csq_cfg_source SRC (.run(run), .slow(slow), .doneIn(glob.doneOut),
    .linkClk(linkClk));
  // 20 MHz system clock
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // hang guard: whole run needs far fewer cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errTotal = errTotal + 1;
      $display("CHECK FAILED at %0t: timeout", $time);
      endOfTest();
    end
  end
  // ----------------------------------------
  // compare and drive tasks
  // ----------------------------------------
  task automatic chkGlob(input csq_glob_t e);
    cmpCount++;
    if (glob !== e) begin
      errTotal++;
      $display("CHECK FAILED at %0t: glob %h exp %h", $time, glob, e);
    end
  endtask
  task automatic chkAcc(input csq_acc_t e);
    cmpCount++;
    if (acc !== e) begin
      errTotal++;
      $display("CHECK FAILED at %0t: acc %h exp %h", $time, acc, e);
    end
  endtask
  task automatic chkBit(input logic got, input logic e, input string w);
    cmpCount++;
    if (got !== e) begin
      errTotal++;
      $display("CHECK FAILED at %0t: %0s is %b", $time, w, got);
    end
  endtask
  // reset with a fresh option set, held ten cycles
  task automatic doReset(input csq_opt_t o);
    opt   = o;
    rst_n = 1'h0;
    repeat (10) @(negedge mclk);
    rst_n = 1'h1;
    @(negedge mclk);
  endtask
  // one-cycle loader event, then one cycle for the answer
  task automatic pulse(input logic chk, input logic mis, input logic rq);
    crcCheck    = chk;
    crcMismatch = mis;
    reconfigReq = rq;
    @(negedge mclk);
    {crcCheck, crcMismatch, reconfigReq} = 3'h0;
    @(negedge mclk);
  endtask
  // load, then follow each link edge with a phase model
  task automatic runSeq(input int nEdges, input int lockLow,
                        input int matchLow);
    csq_ph_t   ph;
    csq_sel_t  mEff;
    logic      done, hit, hitP, gtsR, gweR, ended, stall;
    csq_glob_t e;
    mEff = (opt.matchSel != SEL_AUTO) ? opt.matchSel :
           (opt.usesImpIo ? AUTO_MATCH : 4'hF);
    ph = PH_FIRST;
    {done, hitP, gtsR, gweR, ended} = 5'h00;
    clockLock = (lockLow == 0);
    impMatch  = (matchLow == 0);
    e = {4'h4, !opt.active_reconfig_option, !opt.active_reconfig_option};
    chkGlob(e);
    cfgLoaded = 1'h1;
    @(negedge mclk);
    cfgLoaded = 1'h0;
    run       = 1'h1;
    for (int k = 1; k <= nEdges; k++) begin
      @(posedge linkClk);
      hit  = ({1'h0, ph} >= opt.doneSel);
      done = done | (opt.done_pipeline_option ? hitP : hit);
      hitP = hit;
      gtsR = (opt.gtsSel == SEL_DONE) ? done :
             gtsR | ({1'h0, ph} >= opt.gtsSel);
      gweR = (opt.gweSel == SEL_DONE) ? done :
             gweR | ({1'h0, ph} >= opt.gweSel);
      stall = ({1'h0, ph} == opt.lockSel && !clockLock) ||
              ({1'h0, ph} == mEff && !impMatch);
      if (!ended && !stall) begin
        ended = (ph == PH_LAST);
        ph    = ended ? ph : ph + PH_STEP;
      end
      repeat (6) @(negedge mclk);
      e = {done, !gtsR, gweR, gweR, 1'h0, !gweR && !opt.active_reconfig_option};
      chkGlob(e);
      if (k >= lockLow) clockLock = 1'h1;
      if (k >= matchLow) impMatch = 1'h1;
    end
    run = 1'h0;
    repeat (24) @(negedge mclk);
  endtask
  task automatic note(input string n);
    $display("test %0s ended, mismatches %0d", n, errTotal);
  endtask
  task automatic endOfTest();
    $display("checks %0d, mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    csq_opt_t base, o;
    csq_acc_t ea;
    base = '0;
    base.doneSel  = DEF_DONE;
    base.gtsSel   = DEF_GTS;
    base.gweSel   = DEF_GWE;
    base.lockSel  = SEL_SKIP_WAIT_SETTING;
    base.matchSel = SEL_AUTO;
    {rst_n, cfgLoaded, reconfigReq, crcCheck, crcMismatch} = 5'h00;
    {clockLock, impMatch, run, slow} = 4'hC;
    opt = base;
    // every security, monitor and port setting
    for (int i = 0; i < 3; i++) begin
      o = base;
      o.security     = csq_sec_t'(i);
      o.jtagMon      = csq_mon_t'(i);
      o.portSel      = csq_port_t'(i);
      o.monPowerDown = i[0];
      o.jtagDisable  = 1'h1;
      doReset(o);
      ea = {i == 0, i != 2, 1'h1, i != 1, i == 2, i != 2, i == 2, i[0]};
      chkAcc(ea);
    end
    note("access");
    // defaults, no match wait without calibrated io, level 2
    o = base;
    o.jtagDisable = 1'h1;
    o.frameCrcEn  = 1'h1;
    o.security    = SEC_L2;
    doReset(o);
    runSeq(10, 0, 20);
    chkBit(acc.bscanOk, 1'h0, "scan");
    pulse(1'h1, 1'h0, 1'h0);
    chkBit(initErrN, 1'h1, "init");
    pulse(1'h1, 1'h1, 1'h0);
    chkBit(initErrN, 1'h0, "init");
    chkBit(prErr, 1'h1, "prerr");
    chkBit(loadBlock, 1'h1, "block");
    pulse(1'h0, 1'h0, 1'h1);
    chkBit(glob.doneOut, 1'h1, "done");
    note("default");
    // pipelined done at 1, others follow done, no hold
    o = base;
    o.done_pipeline_option       = 1'h1;
    o.doneSel        = 4'h1;
    o.gtsSel         = SEL_DONE;
    o.gweSel         = SEL_DONE;
    o.active_reconfig_option = 1'h1;
    doReset(o);
    runSeq(10, 0, 0);
    pulse(1'h1, 1'h1, 1'h0);
    chkBit(initErrN, 1'h1, "init");
    pulse(1'h0, 1'h0, 1'h1);
    chkBit(glob.doneOut, 1'h0, "done");
    note("pipe");
    // keep settings never assert
    o = base;
    o.doneSel = SEL_KEEP;
    o.gtsSel  = SEL_KEEP;
    o.gweSel  = 4'h1;
    doReset(o);
    runSeq(10, 0, 0);
    note("keep");
    // lock wait at phase 1 with a long-high source
    o = base;
    o.lockSel = 4'h1;
    slow = 1'h1;
    doReset(o);
    runSeq(12, 3, 0);
    slow = 1'h0;
    note("lock");
    // automatic match phase with calibrated io
    o = base;
    o.usesImpIo = 1'h1;
    doReset(o);
    runSeq(12, 0, 4);
    note("match");
    // both waits skipped while lock and match stay low
    o.matchSel = SEL_SKIP_WAIT_SETTING;
    doReset(o);
    runSeq(10, 20, 20);
    note("skip_wait_setting");
    // match already present at phase 3 costs no stall
    o = base;
    o.matchSel = 4'h3;
    o.lockSel  = 4'h0;
    doReset(o);
    runSeq(10, 0, 0);
    note("ready");
    endOfTest();
  end
endmodule
`default_nettype wire
